// >>> src/cec_pkg.sv
// Package with register layout and constants for the comparator event control block
package cec_pkg;
   // ****************************************
   // Register layout
   // ****************************************
   localparam logic [1:0] ADDR_CTRL_STATUS = 2'h0;
   localparam logic [1:0] ADDR_IRQ_STATUS = 2'h1;
   localparam logic [1:0] ADDR_IRQ_CLEAR = 2'h2;
   localparam logic [1:0] ADDR_IRQ_ENABLE = 2'h3;
   localparam int BIT_POWER_OFF = 7;
   localparam int BIT_BANDGAP_SEL = 6;
   localparam int BIT_RESULT = 5;
   localparam int BIT_EVENT_FLAG = 4;
   localparam int BIT_IRQ_ENABLE = 3;
   localparam int BIT_RESERVED = 2;
   localparam int BIT_SEL_HI = 1;
   localparam int BIT_SEL_LO = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Sticky event bits: 0 comparator event, 1 reference ready
   localparam int EVT_COMPARE = 0;
   localparam int EVT_REF_READY = 1;
   localparam logic [1:0] EVT_RESET = 2'h0;
   // ****************************************
   // Event select codes
   // ****************************************
   localparam logic [1:0] SEL_TOGGLE = 2'h0;
   localparam logic [1:0] SEL_RESERVED = 2'h1;
   localparam logic [1:0] SEL_FALL = 2'h2;
   localparam logic [1:0] SEL_RISE = 2'h3;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 250;
   localparam int REF_STARTUP_US = 10;
   localparam int REF_STARTUP_CYC = REF_STARTUP_US * CLK_MHZ;
endpackage : cec_pkg

// >>> src/cec_if.sv
// Interface joining the edge detector to the control logic
`timescale 1ns/10ps
`default_nettype none
interface cec_edge_if;
   logic result;
   logic rise;
   logic fall;
   modport det (output result, output rise, output fall);
   modport ctl (input result, input rise, input fall);
endinterface : cec_edge_if
`default_nettype wire

// >>> src/cec_sync_edge.sv
// Two-stage synchroniser and edge detector for the comparator result
`timescale 1ns/10ps
`default_nettype none
module cec_sync_edge (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Raw comparator output and gate
   input wire logic raw_result,
   input wire logic powered,
   // Synchronised result and edges
   cec_edge_if.det edge_o
);
   logic meta;
   logic sync;
   logic prev;

   // Two flops before use; first stage read only by second
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= raw_result & powered;
         sync <= meta;
         prev <= sync;
      end
   end

   // Edges seen on the synchronised copy only
   assign edge_o.result = sync;
   assign edge_o.rise = sync & ~prev;
   assign edge_o.fall = ~sync & prev;
endmodule : cec_sync_edge
`default_nettype wire

// >>> src/cec_top.sv
// Comparator control and status, event flag and reference enable logic
// Operation
// - Result high when positive above negative input
// - Bit 5 reads live comparator result
// - Bits 1:0 pick toggle, falling or rising
// - Matching result change sets flag bit 4
// - Interrupt needs flag, enable and global enable
// - Flag clears on vector entry or one-write
// - Bit 7 powers the comparator off
// - Bit 6 feeds bandgap to positive input
// - Bit 2 reads zero; bit 6 without bandgap
// - Reference on with brown-out or bandgap select
`timescale 1ns/10ps
`default_nettype none
module cec_top #(
   parameter bit HAS_BANDGAP = 1'b1,
   parameter int REF_STARTUP_CYC = cec_pkg::REF_STARTUP_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Analog comparator, already a digital level from the analog cell
   input wire logic comparator_raw,
   input wire logic brownout_enable_fuse,
   output logic comparator_power_off,
   output logic bandgap_input_select,
   output logic reference_enable,
   // Processor side
   input wire logic global_irq_enable,
   input wire logic vector_entry,
   output logic comparator_irq,
   output logic sys_irq
);
   // ****************************************
   // Control state
   // ****************************************
   logic irq_enable;
   logic [1:0] event_select;
   logic event_flag;
   logic [1:0] evt_status;
   logic [1:0] evt_enable;
   logic fuse_meta;
   logic fuse_sync;
   logic [12:0] ref_count;
   logic ref_ready;
   logic ref_ready_q;

   cec_edge_if edge_bus ();

   // Result sampled only while powered; the analog cell does the compare
   cec_sync_edge u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .raw_result(comparator_raw),
      .powered(~comparator_power_off),
      .edge_o(edge_bus.det)
   );

   // ****************************************
   // Decode
   // ****************************************
   function automatic logic addr_hit(input logic [1:0] a, input logic [1:0] b);
      addr_hit = (a == b);
   endfunction : addr_hit

   wire wr_ctrl = reg_wr & addr_hit(reg_addr, cec_pkg::ADDR_CTRL_STATUS);
   wire wr_clr = reg_wr & addr_hit(reg_addr, cec_pkg::ADDR_IRQ_CLEAR);
   wire wr_en = reg_wr & addr_hit(reg_addr, cec_pkg::ADDR_IRQ_ENABLE);

   // Event match; the reserved code matches nothing
   wire event_hit = (event_select == cec_pkg::SEL_TOGGLE) ? (edge_bus.rise | edge_bus.fall) :
                    (event_select == cec_pkg::SEL_FALL) ? edge_bus.fall :
                    (event_select == cec_pkg::SEL_RISE) ? edge_bus.rise : 1'b0;
   wire flag_clr = (wr_ctrl & reg_wdata[cec_pkg::BIT_EVENT_FLAG]) | vector_entry;
   // Set wins over clear so no event is lost
   wire next_flag = event_hit | (event_flag & ~flag_clr);
   wire brownout_enable_fuse_q = fuse_sync;
   wire ref_on = brownout_enable_fuse_q | bandgap_input_select;
   wire ref_done = (ref_count == REF_STARTUP_CYC[12:0]);
   wire [1:0] evt_set = {ref_ready & ~ref_ready_q, event_hit};
   wire [1:0] next_evt = evt_set | (evt_status & ~(wr_clr ? reg_wdata[1:0] : 2'h0));

   // Live view of control register; reserved bit 2 reads zero
   wire [7:0] ctrl_view = {comparator_power_off,
                           bandgap_input_select & HAS_BANDGAP,
                           edge_bus.result,
                           event_flag,
                           irq_enable,
                           1'b0,
                           event_select};
   wire [7:0] rd_mux = addr_hit(reg_addr, cec_pkg::ADDR_CTRL_STATUS) ? ctrl_view :
                       addr_hit(reg_addr, cec_pkg::ADDR_IRQ_STATUS) ? {6'h00, evt_status} :
                       addr_hit(reg_addr, cec_pkg::ADDR_IRQ_ENABLE) ? {6'h00, evt_enable} :
                       8'h00;

   // ****************************************
   // Register writes
   // ****************************************
   // Control bits; reset leaves comparator on, pin input, toggle, irq off
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         comparator_power_off <= 1'b0;
         bandgap_input_select <= 1'b0;
         irq_enable <= 1'b0;
         event_select <= cec_pkg::SEL_TOGGLE;
         event_flag <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            comparator_power_off <= reg_wdata[cec_pkg::BIT_POWER_OFF];
            bandgap_input_select <= reg_wdata[cec_pkg::BIT_BANDGAP_SEL] & HAS_BANDGAP;
            irq_enable <= reg_wdata[cec_pkg::BIT_IRQ_ENABLE];
            event_select <= reg_wdata[cec_pkg::BIT_SEL_HI:cec_pkg::BIT_SEL_LO];
         end
         event_flag <= next_flag;
      end
   end

   // Sticky status and enable registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         evt_status <= cec_pkg::EVT_RESET;
         evt_enable <= cec_pkg::EVT_RESET;
      end else begin
         evt_status <= next_evt;
         if (wr_en) begin
            evt_enable <= reg_wdata[1:0];
         end
      end
   end

   // Fuse level comes from outside, so it is synchronised first
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         fuse_meta <= 1'b0;
         fuse_sync <= 1'b0;
      end else begin
         fuse_meta <= brownout_enable_fuse;
         fuse_sync <= fuse_meta;
      end
   end

   // Start-up counter; ready only after the full wait, restarted when off
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ref_count <= 13'h0000;
         ref_ready <= 1'b0;
         ref_ready_q <= 1'b0;
         reference_enable <= 1'b0;
      end else begin
         reference_enable <= ref_on;
         ref_ready_q <= ref_ready;
         if (!ref_on) begin
            ref_count <= 13'h0000;
            ref_ready <= 1'b0;
         end else if (!ref_done) begin
            ref_count <= ref_count + 13'h0001;
         end else begin
            ref_ready <= 1'b1;
         end
      end
   end

   // Outputs registered; interrupt uses the next flag to stay aligned
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         comparator_irq <= 1'b0;
         sys_irq <= 1'b0;
         reg_rdata <= 8'h00;
      end else begin
         comparator_irq <= next_flag & irq_enable & global_irq_enable;
         sys_irq <= |(next_evt & evt_enable);
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_irq_needs_enable;
      @(posedge core_clk) disable iff (!rst_n) comparator_irq |-> $past(irq_enable);
   endproperty
   a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("irq without enable");

   property p_flag_clear;
      @(posedge core_clk) disable iff (!rst_n)
         (vector_entry && !event_hit) |=> !event_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

   property p_flag_set;
      @(posedge core_clk) disable iff (!rst_n) event_hit |=> event_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set on event");

   property p_reserved_zero;
      @(posedge core_clk) disable iff (!rst_n) !ctrl_view[cec_pkg::BIT_RESERVED];
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_ref_off;
      @(posedge core_clk) disable iff (!rst_n)
         (!fuse_sync && !bandgap_input_select) |=> !reference_enable;
   endproperty
   a_ref_off: assert property (p_ref_off) else $error("reference on while unused");

   property p_rise_select;
      @(posedge core_clk) disable iff (!rst_n)
         (event_select == cec_pkg::SEL_RISE && edge_bus.fall && !event_flag) |=> !event_flag;
   endproperty
   a_rise_select: assert property (p_rise_select) else $error("fall flagged in rise mode");

   property p_power_write;
      @(posedge core_clk) disable iff (!rst_n)
         wr_ctrl |=> comparator_power_off == $past(reg_wdata[cec_pkg::BIT_POWER_OFF]);
   endproperty
   a_power_write: assert property (p_power_write) else $error("power bit not written");

   sequence s_raw_high;
      comparator_raw && !comparator_power_off ##1 comparator_raw && !comparator_power_off;
   endsequence
   property p_sync_delay;
      @(posedge core_clk) disable iff (!rst_n) s_raw_high |=> edge_bus.result;
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("result not synchronised");

   // ****************************************
   // Flag, interrupt and register checks
   // ****************************************
   // A zero write or no clear leaves the flag standing
   property p_flag_hold;
      @(posedge core_clk) disable iff (!rst_n) (event_flag && !flag_clr) |=> event_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear");

   // Writing a one to the flag bit clears it
   property p_flag_write_clear;
      @(posedge core_clk) disable iff (!rst_n)
         (wr_ctrl && reg_wdata[cec_pkg::BIT_EVENT_FLAG] && !event_hit) |=> !event_flag;
   endproperty
   a_flag_write_clear: assert property (p_flag_write_clear) else $error("flag write");

   // All three causes present give a request next cycle
   property p_irq_on;
      @(posedge core_clk) disable iff (!rst_n)
         (next_flag && irq_enable && global_irq_enable) |=> comparator_irq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq missing");

   // Local enable low blocks the request
   property p_irq_off_local;
      @(posedge core_clk) disable iff (!rst_n) !irq_enable |=> !comparator_irq;
   endproperty
   a_irq_off_local: assert property (p_irq_off_local) else $error("irq while disabled");

   // Global enable low blocks the request
   property p_irq_off_global;
      @(posedge core_clk) disable iff (!rst_n) !global_irq_enable |=> !comparator_irq;
   endproperty
   a_irq_off_global: assert property (p_irq_off_global) else $error("irq while masked");

   // The request never stands without the flag
   property p_irq_needs_flag;
      @(posedge core_clk) disable iff (!rst_n) comparator_irq |-> event_flag;
   endproperty
   a_irq_needs_flag: assert property (p_irq_needs_flag) else $error("irq without flag");

   // Falling mode ignores rising edges
   property p_fall_select;
      @(posedge core_clk) disable iff (!rst_n)
         (event_select == cec_pkg::SEL_FALL && edge_bus.rise && !event_flag) |=> !event_flag;
   endproperty
   a_fall_select: assert property (p_fall_select) else $error("rise flagged in fall mode");

   // The reserved code flags nothing
   property p_reserved_code;
      @(posedge core_clk) disable iff (!rst_n)
         (event_select == cec_pkg::SEL_RESERVED && !event_flag) |=> !event_flag;
   endproperty
   a_reserved_code: assert property (p_reserved_code) else $error("reserved code flagged");

   // Toggle mode flags either edge
   property p_toggle_select;
      @(posedge core_clk) disable iff (!rst_n)
         (event_select == cec_pkg::SEL_TOGGLE && (edge_bus.rise || edge_bus.fall)) |=> event_flag;
   endproperty
   a_toggle_select: assert property (p_toggle_select) else $error("toggle not flagged");

   // A control read shows the live result of the strobe cycle
   property p_result_read;
      @(posedge core_clk) disable iff (!rst_n)
         (reg_rd && reg_addr == cec_pkg::ADDR_CTRL_STATUS)
            |=> reg_rdata[cec_pkg::BIT_RESULT] == $past(edge_bus.result);
   endproperty
   a_result_read: assert property (p_result_read) else $error("result bit wrong");

   // Read data are zero outside the answer cycle
   property p_rdata_idle;
      @(posedge core_clk) disable iff (!rst_n) !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

   // Bandgap select follows the write where the variant has it
   property p_bandgap_write;
      @(posedge core_clk) disable iff (!rst_n)
         wr_ctrl |=> bandgap_input_select == $past(reg_wdata[cec_pkg::BIT_BANDGAP_SEL] & HAS_BANDGAP);
   endproperty
   a_bandgap_write: assert property (p_bandgap_write) else $error("bandgap bit wrong");

   // Interrupt enable follows the write
   property p_irq_enable_write;
      @(posedge core_clk) disable iff (!rst_n)
         wr_ctrl |=> irq_enable == $past(reg_wdata[cec_pkg::BIT_IRQ_ENABLE]);
   endproperty
   a_irq_enable_write: assert property (p_irq_enable_write) else $error("enable bit wrong");

   // Select field follows the write
   property p_select_write;
      @(posedge core_clk) disable iff (!rst_n)
         wr_ctrl |=> event_select == $past(reg_wdata[cec_pkg::BIT_SEL_HI:cec_pkg::BIT_SEL_LO]);
   endproperty
   a_select_write: assert property (p_select_write) else $error("select field wrong");

   // Without a write the select field and interrupt enable hold
   property p_ctrl_keep;
      @(posedge core_clk) disable iff (!rst_n)
         !wr_ctrl |=> $stable(event_select) && $stable(irq_enable);
   endproperty
   a_ctrl_keep: assert property (p_ctrl_keep) else $error("control bits drifted");

   // Reference must be on while either user needs it
   property p_ref_on;
      @(posedge core_clk) disable iff (!rst_n)
         (fuse_sync || bandgap_input_select) |=> reference_enable;
   endproperty
   a_ref_on: assert property (p_ref_on) else $error("reference off while used");

   // Three cycles powered off leave the synchronised result low
   sequence s_powered_off;
      comparator_power_off ##1 comparator_power_off ##1 comparator_power_off;
   endsequence
   property p_power_gate;
      @(posedge core_clk) disable iff (!rst_n) s_powered_off |=> !edge_bus.result;
   endproperty
   a_power_gate: assert property (p_power_gate) else $error("result high while off");

   // Reset clears control bits, flag and request; checked through reset itself
   property p_reset_state;
      @(posedge core_clk) !rst_n |=> (!comparator_power_off && !bandgap_input_select &&
         !irq_enable && event_select == cec_pkg::SEL_TOGGLE && !event_flag && !comparator_irq);
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

   // Sticky comparator bit records every event
   property p_sticky_set;
      @(posedge core_clk) disable iff (!rst_n) event_hit |=> evt_status[cec_pkg::EVT_COMPARE];
   endproperty
   a_sticky_set: assert property (p_sticky_set) else $error("sticky bit not set");

   // Enabled sticky bits raise the level interrupt
   property p_sys_irq;
      @(posedge core_clk) disable iff (!rst_n) ((next_evt & evt_enable) != 2'h0) |=> sys_irq;
   endproperty
   a_sys_irq: assert property (p_sys_irq) else $error("system irq missing");
endmodule : cec_top
`default_nettype wire

// >>> dv/test_comparator_event_control.sv
// Self-checking testbench for the comparator event control block
`timescale 1ns/10ps
`default_nettype none
module test_comparator_event_control;
   // ****************************************
   // Stimulus and observation signals
   // ****************************************
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic comparator_raw = 1'b0;
   logic brownout_enable_fuse = 1'b0;
   logic global_irq_enable = 1'b0;
   logic vector_entry = 1'b0;
   logic comparator_power_off, bandgap_input_select, reference_enable;
   logic comparator_irq, sys_irq;
   int n_mismatch = 0;
   int compares = 0;
   logic [7:0] d, v;

   // Short start-up count keeps the reference wait brief in simulation
   cec_top #(.HAS_BANDGAP(1'b1), .REF_STARTUP_CYC(8)) uut (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .comparator_raw(comparator_raw), .brownout_enable_fuse(brownout_enable_fuse),
      .comparator_power_off(comparator_power_off),
      .bandgap_input_select(bandgap_input_select), .reference_enable(reference_enable),
      .global_irq_enable(global_irq_enable), .vector_entry(vector_entry),
      .comparator_irq(comparator_irq), .sys_irq(sys_irq)
   );

   // 250 MHz core clock
   always #2 core_clk = ~core_clk;

   // ****************************************
   // Shared tasks and expectation functions
   // ****************************************
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
   endtask : step

   // Strobes last one cycle; the next call waits for a fresh edge
   task automatic wr(input logic [1:0] a, input logic [7:0] w);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= w;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, output logic [7:0] r);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 r = reg_rdata;
   endtask : rd

   // Whether a result edge should raise the flag under a select code
   function automatic logic exp_flag(input logic [1:0] s, input logic up);
      case (s)
         cec_pkg::SEL_TOGGLE: exp_flag = 1'b1;
         cec_pkg::SEL_FALL: exp_flag = ~up;
         cec_pkg::SEL_RISE: exp_flag = up;
         default: exp_flag = 1'b0;
      endcase
   endfunction : exp_flag

   task automatic summarize;
      if (n_mismatch == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize

   // Watchdog sized well above the expected run length
   initial begin
      #40000;
      n_mismatch++;
      summarize();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h6621));
      step(8);
      rst_n <= 1'b1;
      rd(cec_pkg::ADDR_CTRL_STATUS, d);
      chk("ctrl_reset", d, cec_pkg::CTRL_RESET);
      chk("outs_reset", {comparator_power_off, bandgap_input_select, comparator_irq}, 8'h00);
      global_irq_enable <= 1'b1;
      // Every select code against a rising and a falling result
      for (int s = 0; s < 4; s++) begin
         wr(cec_pkg::ADDR_CTRL_STATUS, 8'h10 | 8'(s));
         comparator_raw <= 1'b1;
         step(6);
         rd(cec_pkg::ADDR_CTRL_STATUS, d);
         chk("rise_view", d, {3'h1, exp_flag(2'(s), 1'b1), 2'h0, 2'(s)});
         chk("irq_masked", {7'h0, comparator_irq}, 8'h00);
         wr(cec_pkg::ADDR_CTRL_STATUS, 8'h10 | 8'(s));
         comparator_raw <= 1'b0;
         step(6);
         rd(cec_pkg::ADDR_CTRL_STATUS, d);
         chk("fall_view", d, {3'h0, exp_flag(2'(s), 1'b0), 2'h0, 2'(s)});
      end
      // Flag kept by a zero write, gated by the global enable, cleared on vector entry
      comparator_raw <= 1'b1;
      step(6);
      wr(cec_pkg::ADDR_CTRL_STATUS, 8'h0b);
      step(2);
      chk("irq_on", {7'h0, comparator_irq}, 8'h01);
      global_irq_enable <= 1'b0;
      step(2);
      chk("irq_global", {7'h0, comparator_irq}, 8'h00);
      global_irq_enable <= 1'b1;
      @(posedge core_clk);
      vector_entry <= 1'b1;
      @(posedge core_clk);
      vector_entry <= 1'b0;
      step(2);
      rd(cec_pkg::ADDR_CTRL_STATUS, d);
      chk("vector_clear", d, 8'h2b);
      chk("vector_irq", {7'h0, comparator_irq}, 8'h00);
      // Sticky status, enable and clear registers
      wr(cec_pkg::ADDR_CTRL_STATUS, 8'h13);
      wr(cec_pkg::ADDR_IRQ_CLEAR, 8'h03);
      wr(cec_pkg::ADDR_IRQ_ENABLE, 8'h01);
      comparator_raw <= 1'b0;
      step(6);
      comparator_raw <= 1'b1;
      step(6);
      rd(cec_pkg::ADDR_IRQ_STATUS, d);
      chk("sticky_set", d & 8'h01, 8'h01);
      chk("sticky_irq", {7'h0, sys_irq}, 8'h01);
      wr(cec_pkg::ADDR_IRQ_CLEAR, 8'h01);
      step(2);
      rd(cec_pkg::ADDR_IRQ_STATUS, d);
      chk("sticky_clr", d & 8'h01, 8'h00);
      chk("sticky_irq_clr", {7'h0, sys_irq}, 8'h00);
      rd(cec_pkg::ADDR_IRQ_CLEAR, d);
      chk("clear_reads_zero", d, 8'h00);
      // Random control writes with a quiet comparator input
      comparator_raw <= 1'b0;
      step(6);
      repeat (24) begin
         v = 8'($urandom) & 8'hcf | 8'h10;
         brownout_enable_fuse <= 1'($urandom);
         step(3);
         wr(cec_pkg::ADDR_CTRL_STATUS, v);
         rd(cec_pkg::ADDR_CTRL_STATUS, d);
         chk("rand_ctrl", d, v & 8'hcb);
         chk("rand_pins", {comparator_power_off, bandgap_input_select, reference_enable},
             {v[7], v[6], v[6] | brownout_enable_fuse});
      end
      // Reference start-up with the comparator on, then power-off forces result low
      // Reference forced off first so its ready edge is fresh
      brownout_enable_fuse <= 1'b0;
      wr(cec_pkg::ADDR_CTRL_STATUS, 8'h10);
      step(4);
      wr(cec_pkg::ADDR_CTRL_STATUS, 8'h50);
      wr(cec_pkg::ADDR_IRQ_CLEAR, 8'h03);
      step(20);
      rd(cec_pkg::ADDR_IRQ_STATUS, d);
      chk("ref_ready", {d[1], reference_enable}, 8'h03);
      comparator_raw <= 1'b1;
      wr(cec_pkg::ADDR_CTRL_STATUS, 8'h90);
      step(6);
      rd(cec_pkg::ADDR_CTRL_STATUS, d);
      chk("power_off", d & 8'hef, 8'h80);
      summarize();
   end
endmodule : test_comparator_event_control
`default_nettype wire
